// File: include/acc_consts.svh
// Constants for the comparator control block: offsets, bit positions, resets.
// Assumes inclusion by bare name from design and bench files.
`ifndef ACC_CONSTS_SVH
`define ACC_CONSTS_SVH

// Register byte offsets on the AXI4-Lite slave
`define ACC_OFF_SFIO 8'h00
`define ACC_OFF_CSR 8'h04
`define ACC_OFF_CONV 8'h08
`define ACC_OFF_IRQ_STAT 8'h0c
`define ACC_OFF_IRQ_MASK 8'h10
`define ACC_OFF_GLOBAL 8'h14

// Special function register fields
`define ACC_SFIO_TRIG_LSB 5
`define ACC_SFIO_UNUSED 4
`define ACC_SFIO_MUX_EN 3
`define ACC_SFIO_PULLUP_OFF 2
`define ACC_SFIO_PRESC_RST_T2 1
`define ACC_SFIO_PRESC_RST_T01 0
`define ACC_SFIO_RESET 8'h00
`define ACC_SFIO_WMASK 8'hef

// Control and status register fields
`define ACC_CSR_DISABLE 7
`define ACC_CSR_BANDGAP 6
`define ACC_CSR_OUT 5
`define ACC_CSR_FLAG 4
`define ACC_CSR_IRQ_EN 3
`define ACC_CSR_CAPTURE 2
`define ACC_CSR_MODE_HI 1
`define ACC_CSR_MODE_LO 0
`define ACC_CSR_RESET 8'h00

// Converter control: bit 7 enable, bits 2..0 channel select
`define ACC_CONV_EN 7
`define ACC_CONV_RESET 8'h00

`endif

// File: include/acc_pkg.sv
// Types shared by the comparator control block.
// Assumes no other package.
package acc_pkg;
    typedef enum logic [1:0] {
        ACC_MODE_TOGGLE = 2'h0,
        ACC_MODE_RSVD = 2'h1,
        ACC_MODE_FALL = 2'h2,
        ACC_MODE_RISE = 2'h3
    } acc_mode_e;
    typedef logic [2:0] acc_chan_t;
endpackage

// File: logic/acc_sync.sv
// Two flip-flop synchroniser for the asynchronous comparator output.
// Assumes aclk domain and a synchronous active low reset.
`timescale 1ns/1ps
module acc_sync (
    // Clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // Data
    input wire logic d_async,
    output logic q
);
    logic meta_reg;
    logic sync_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
        end else if (ce) begin
            meta_reg <= d_async;
            sync_reg <= meta_reg;
        end
    end

    assign q = sync_reg;
endmodule

// File: logic/acc_top.sv
// Comparator control: input routing, output sync, edge interrupt, capture route.
// Assumes an AXI4-Lite master on aclk; analog core outputs arrive asynchronously.
`timescale 1ns/1ps
`include "acc_consts.svh"

// Operation
// - Mux enable set and converter off: negative input comes from channel mux
// - Mux enable clear: dedicated negative pin feeds negative input
// - Channel field 000..111 picks analog pin 0..7 while routing is active
// - Disable bit 7 powers comparator down, writable any time
// - Bandgap bit 6 picks reference for positive input, else positive pin
// - Output status bit 5 is synchronised output, one to two cycles late
// - Flag bit 4 sets on the event chosen by mode field
// - Flag clears when its interrupt vector is executed
// - Writing one to flag clears it, zero leaves it
// - Request only while flag, enable bit 3 and global enable set
// - Capture bit 2 set drives comparator output to capture front end
// - Capture bit clear fully disconnects comparator from capture
// - Mode 00 toggle, 01 reserved, 10 falling, 11 rising
// - Output high when positive input exceeds negative input
// - Converter enable bit gates the comparator multiplexer routing
module acc_top (
    // Clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // AXI4-Lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Analog core
    input wire logic comparator_raw,
    output logic comparator_disable,
    output logic bandgap_select,
    output logic neg_from_mux,
    output logic [2:0] neg_channel,
    // Converter side, timer side, core
    output logic converter_enable,
    output logic capture_input,
    input wire logic vector_ack,
    output logic irq_request,
    output logic irq
);
    logic [7:0] sfio_reg;
    logic [7:0] csr_reg;
    logic [7:0] conv_reg;
    logic global_en_reg;
    logic [1:0] stat_reg;
    logic [1:0] mask_reg;
    logic out_sync;
    logic out_prev_reg;
    logic event_hit;
    logic aw_held_reg;
    logic w_held_reg;
    logic [7:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic wr_go;
    logic [7:0] wbyte;
    logic flag_clr;
    logic flag_set;
    logic vec_clr;

    // ****************************************
    // Output synchroniser
    // ****************************************
    acc_sync u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .d_async(comparator_raw),
        .q(out_sync)
    );

    // ****************************************
    // AXI4-Lite write path
    // ****************************************
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a[7:2] == off[7:2]);
    endfunction

    assign wr_go = aw_held_reg && w_held_reg && !s_axi_bvalid;
    assign wbyte = w_strb_reg[0] ? w_data_reg[7:0] : 8'h00;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end else if (ce) begin
            s_axi_awready <= !aw_held_reg && !s_axi_awready;
            s_axi_wready <= !w_held_reg && !s_axi_wready;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_addr_reg > `ACC_OFF_IRQ_MASK + 8'h07) ? 2'h2 : 2'h0;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ****************************************
    // Control registers
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sfio_reg <= `ACC_SFIO_RESET;
            conv_reg <= `ACC_CONV_RESET;
            global_en_reg <= 1'b0;
            mask_reg <= 2'h0;
        end else if (ce && wr_go) begin
            if (hit(aw_addr_reg, `ACC_OFF_SFIO)) begin
                sfio_reg <= wbyte & `ACC_SFIO_WMASK;
            end
            if (hit(aw_addr_reg, `ACC_OFF_CONV)) begin
                conv_reg <= wbyte;
            end
            if (hit(aw_addr_reg, `ACC_OFF_GLOBAL)) begin
                global_en_reg <= wbyte[0];
            end
            if (hit(aw_addr_reg, `ACC_OFF_IRQ_MASK)) begin
                mask_reg <= wbyte[1:0];
            end
        end
    end

    // Flag bit is hardware-owned; write path only touches bits 7..6 and 3..0
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            csr_reg <= `ACC_CSR_RESET;
        end else if (ce && wr_go && hit(aw_addr_reg, `ACC_OFF_CSR)) begin
            csr_reg[7:6] <= wbyte[7:6];
            csr_reg[3:0] <= wbyte[3:0];
        end
    end

    // ****************************************
    // Event detection and flag
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            out_prev_reg <= 1'b0;
        end else if (ce) begin
            out_prev_reg <= out_sync;
        end
    end

    // Reserved mode never fires; a disable may still look like an edge
    always_comb begin
        unique case (acc_pkg::acc_mode_e'(csr_reg[1:0]))
            acc_pkg::ACC_MODE_TOGGLE: event_hit = out_sync ^ out_prev_reg;
            acc_pkg::ACC_MODE_RSVD: event_hit = 1'b0;
            acc_pkg::ACC_MODE_FALL: event_hit = out_prev_reg && !out_sync;
            acc_pkg::ACC_MODE_RISE: event_hit = !out_prev_reg && out_sync;
        endcase
    end

    assign flag_set = event_hit;
    assign flag_clr = wr_go && hit(aw_addr_reg, `ACC_OFF_CSR) && wbyte[`ACC_CSR_FLAG];
    assign vec_clr = vector_ack && irq_request;

    // Status bit 0 mirrors the flag; set wins over every clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stat_reg <= 2'h0;
        end else if (ce) begin
            if (flag_set) begin
                stat_reg[0] <= 1'b1;
            end else if (flag_clr || vec_clr ||
                         (wr_go && hit(aw_addr_reg, `ACC_OFF_IRQ_STAT) && wbyte[0])) begin
                stat_reg[0] <= 1'b0;
            end
            if (flag_set && csr_reg[`ACC_CSR_IRQ_EN]) begin
                stat_reg[1] <= 1'b1;
            end else if (wr_go && hit(aw_addr_reg, `ACC_OFF_IRQ_STAT) && wbyte[1]) begin
                stat_reg[1] <= 1'b0;
            end
        end
    end

    // ****************************************
    // Outputs to core, converter and timer
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            comparator_disable <= 1'b0;
            bandgap_select <= 1'b0;
            neg_from_mux <= 1'b0;
            neg_channel <= 3'h0;
            converter_enable <= 1'b0;
            capture_input <= 1'b0;
            irq_request <= 1'b0;
            irq <= 1'b0;
        end else if (ce) begin
            comparator_disable <= csr_reg[`ACC_CSR_DISABLE];
            bandgap_select <= csr_reg[`ACC_CSR_BANDGAP];
            neg_from_mux <= sfio_reg[`ACC_SFIO_MUX_EN] && !conv_reg[`ACC_CONV_EN];
            neg_channel <= acc_pkg::acc_chan_t'(conv_reg[2:0]);
            converter_enable <= conv_reg[`ACC_CONV_EN];
            capture_input <= csr_reg[`ACC_CSR_CAPTURE] && out_sync;
            irq_request <= stat_reg[0] && csr_reg[`ACC_CSR_IRQ_EN] && global_en_reg
                           && !vec_clr;
            irq <= |(stat_reg & mask_reg);
        end
    end

    // ****************************************
    // AXI4-Lite read path
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h0;
        end else if (ce) begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= 2'h0;
                s_axi_rdata <= 32'h0000_0000;
                if (hit(s_axi_araddr, `ACC_OFF_SFIO)) begin
                    s_axi_rdata[7:0] <= sfio_reg;
                end else if (hit(s_axi_araddr, `ACC_OFF_CSR)) begin
                    s_axi_rdata[7:0] <= {csr_reg[7:6], out_sync, stat_reg[0],
                                         csr_reg[3:0]};
                end else if (hit(s_axi_araddr, `ACC_OFF_CONV)) begin
                    s_axi_rdata[7:0] <= conv_reg;
                end else if (hit(s_axi_araddr, `ACC_OFF_IRQ_STAT)) begin
                    s_axi_rdata[1:0] <= stat_reg;
                end else if (hit(s_axi_araddr, `ACC_OFF_IRQ_MASK)) begin
                    s_axi_rdata[1:0] <= mask_reg;
                end else if (hit(s_axi_araddr, `ACC_OFF_GLOBAL)) begin
                    s_axi_rdata[0] <= global_en_reg;
                end else begin
                    s_axi_rresp <= 2'h2;
                end
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule

// File: tb/acc_core_model.sv
// Behavioural analog comparator core beside the control block.
// Assumes levels given as 8-bit codes by the bench.
`timescale 1ns/1ps
module acc_core_model #(
    parameter logic [7:0] BANDGAP_MV = 8'ha0
) (
    // Control from the block
    input wire logic comparator_disable,
    input wire logic bandgap_select,
    input wire logic neg_from_mux,
    input wire logic [2:0] neg_channel,
    // Analog levels
    input wire logic [7:0] pos_mv,
    input wire logic [7:0] neg_mv,
    input wire logic [63:0] adc_mv,
    // Result
    output logic comparator_raw
);
    logic [7:0] plus_v;
    logic [7:0] minus_v;
    assign plus_v = bandgap_select ? BANDGAP_MV : pos_mv;
    assign minus_v = neg_from_mux ? adc_mv[neg_channel*8 +: 8] : neg_mv;
    // Powered down core parks low, so a disable may look like a fall
    assign comparator_raw = !comparator_disable && (plus_v > minus_v);
endmodule

// File: tb/acc_top_sva.sv
// Port checker for the comparator control block.
// Assumes one clock domain and a synchronous active low reset.
`timescale 1ns/1ps
module acc_top_sva (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Comparator side
    input wire logic comparator_raw,
    input wire logic neg_from_mux,
    input wire logic converter_enable,
    input wire logic capture_input,
    input wire logic vector_ack,
    input wire logic irq_request
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence both_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    a_write_answer: assert property (both_taken |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
        else $error("read response late");
    a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
    a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
    a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read bits set");
    a_neg_route: assert property (
        neg_from_mux |-> !converter_enable)
        else $error("mux route with converter on");
    a_capture_src: assert property (
        capture_input |-> $past(comparator_raw, 2) || $past(comparator_raw, 3)
        || $past(comparator_raw, 4)) else $error("capture without output");
    a_vector_clear: assert property (irq_request && vector_ack |=> !irq_request)
        else $error("vector did not clear");
endmodule
bind acc_top acc_top_sva acc_top_sva_i (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .comparator_raw,
    .neg_from_mux, .converter_enable, .capture_input, .vector_ack, .irq_request);

// File: tb/tb.sv
// Self-checking bench for the comparator control block.
// Assumes the core model drives the raw comparator output.
`timescale 1ns/1ps
`include "acc_consts.svh"
module tb;
    logic aclk, aresetn, ce, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0] s_axi_awaddr, s_axi_araddr, pos_mv, neg_mv, d;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic comparator_raw, comparator_disable, bandgap_select, neg_from_mux, converter_enable;
    logic capture_input, vector_ack, irq_request, irq;
    logic [2:0] neg_channel, ch;
    logic [63:0] adc_mv;
    int mismatches, checked;
    integer seed;
    bit lazy;
    acc_top acc_top_i (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .comparator_raw, .comparator_disable,
        .bandgap_select, .neg_from_mux, .neg_channel, .converter_enable, .capture_input,
        .vector_ack, .irq_request, .irq);
    acc_core_model acc_core_model_i (.comparator_disable, .bandgap_select, .neg_from_mux,
        .neg_channel, .pos_mv, .neg_mv, .adc_mv, .comparator_raw);
    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end
    // ****
    // Tasks
    // ****
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task stop_test();
        $display("mismatches=%0d checked=%0d", mismatches, checked);
        if (mismatches == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task wr(input logic [7:0] a, input logic [7:0] v);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, v};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= !lazy;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'b1;
        end while (!(s_axi_bvalid && s_axi_bready));
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask
    task rd(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= !lazy;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'b1;
        end while (!(s_axi_rvalid && s_axi_rready));
        d = s_axi_rdata[7:0];
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask
    // Level change then room for sync, flag and request stages
    task lvl(input logic hi);
        pos_mv <= hi ? (8'hc0 | 8'($random(seed))) : (8'h7f & 8'($random(seed)));
        repeat (6) @(posedge aclk);
    endtask
    function automatic logic fexp(input logic [1:0] m, input logic rise);
        return m == 2'h0 || (m == 2'h3 && rise) || (m == 2'h2 && !rise);
    endfunction
    // ****
    // Sequence
    // ****
    initial begin
        seed = 32'hd800;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, adc_mv} = '0;
        {aresetn, vector_ack, pos_mv, neg_mv, s_axi_wstrb, ce} = {10'h0, 8'h80, 5'h3};
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(`ACC_OFF_CSR);
        chk(d, 8'h00);
        wr(`ACC_OFF_SFIO, 8'hff);
        rd(`ACC_OFF_SFIO);
        chk(d, 8'hef);
        // Late ready holds the answer on the bus for a cycle
        lazy = 1'b1;
        rd(8'h40);
        chk(r, 2'h2);
        wr(8'h40, 8'h5a);
        chk(r, 2'h2);
        lazy = 1'b0;
        adc_mv <= {$random(seed), $random(seed)};
        for (int i = 0; i < 4; i++) begin
            ch = 3'($random(seed));
            wr(`ACC_OFF_SFIO, {4'h0, i[0], 3'h0});
            wr(`ACC_OFF_CONV, {i[1], 4'h0, ch});
            chk(neg_from_mux, i[0] & !i[1]);
            chk(neg_channel, ch);
        end
        wr(`ACC_OFF_SFIO, 8'h00);
        for (int m = 0; m < 4; m++) begin
            lvl(1'b0);
            wr(`ACC_OFF_CSR, {4'h1, 2'h0, 2'(m)});
            lvl(1'b1);
            wr(`ACC_OFF_CSR, {6'h0, 2'(m)});
            rd(`ACC_OFF_CSR);
            chk(d, {3'h1, fexp(2'(m), 1'b1), 2'h0, 2'(m)});
            wr(`ACC_OFF_CSR, {4'h1, 2'h0, 2'(m)});
            lvl(1'b0);
            rd(`ACC_OFF_CSR);
            chk(d, {3'h0, fexp(2'(m), 1'b0), 2'h0, 2'(m)});
        end
        wr(`ACC_OFF_IRQ_MASK, 8'h01);
        wr(`ACC_OFF_GLOBAL, 8'h01);
        wr(`ACC_OFF_CSR, 8'h1b);
        lvl(1'b1);
        chk(irq_request, 1'b1);
        chk(irq, 1'b1);
        vector_ack <= 1'b1;
        @(posedge aclk);
        vector_ack <= 1'b0;
        repeat (3) @(posedge aclk);
        chk(irq_request, 1'b0);
        wr(`ACC_OFF_IRQ_STAT, 8'h01);
        chk(irq, 1'b0);
        lvl(1'b0);
        lvl(1'b1);
        wr(`ACC_OFF_CSR, 8'h1b);
        chk(irq_request, 1'b0);
        wr(`ACC_OFF_GLOBAL, 8'h00);
        lvl(1'b0);
        lvl(1'b1);
        chk(irq_request, 1'b0);
        rd(`ACC_OFF_IRQ_STAT);
        chk(d, 8'h03);
        wr(`ACC_OFF_IRQ_STAT, 8'h03);
        chk(irq, 1'b0);
        rd(`ACC_OFF_IRQ_STAT);
        chk(d, 8'h00);
        wr(`ACC_OFF_CSR, 8'h04);
        lvl(1'b1);
        chk(capture_input, 1'b1);
        lvl(1'b0);
        chk(capture_input, 1'b0);
        lvl(1'b1);
        wr(`ACC_OFF_CSR, 8'h00);
        chk(capture_input, 1'b0);
        wr(`ACC_OFF_CSR, 8'hc0);
        chk({comparator_disable, bandgap_select}, 2'h3);
        lvl(1'b0);
        wr(`ACC_OFF_CSR, 8'h40);
        repeat (4) @(posedge aclk);
        rd(`ACC_OFF_CSR);
        chk(d & 8'he0, 8'h60);
        stop_test();
    end
    initial begin
        repeat (20000) @(posedge aclk);
        mismatches++;
        stop_test();
    end
endmodule
